// ---- hw/area_sensor_clock_sequencer.sv ----
/*
 * clock sequencer driving a two-phase full-frame area sensor: vertical
 * phases, transfer gate, horizontal phases, summing gate and reset gate.
 * assumes level shifters and MOS drivers outside; phase pairs are driven
 * as exact complements so they cross mid-swing after the damping network.
 */
// Functional notes
// - seven controls: two vertical, transfer, two horizontal, summing, reset.
// - transfer gate is its own output, timed exactly as vertical phase two.
// - tying transfer gate to vertical phase two also works; same waveform.
// - four modes selected only by ordering and counts of sequences.
// - line binning: shift binned rows down, then read whole horizontal line.
// - line binning: summing gate identical to horizontal phase two.
// - area scan: read whole line after each row; frame ends after last row.
// - area scan: summing gate identical to horizontal phase two.
// - pixel binning: hold summing gate across binned pixels to merge them.
// - line binning and pixel binning may combine in one readout.
// - time-delay integration: vertical shifts paced to object motion.
// - complementary phase pairs cross at half amplitude.
// - split-register sensor: transfer gate equals half-A vertical phase two.
// - pulse reset gate before each new pixel charge arrives.
// - reset pulse held about 10 ns to 100 ns, longer is fine.
`timescale 1ns/10ps
`include "seq_map.svh"
module area_sensor_clock_sequencer #(
    parameter int COUNT_W = `SEQ_COUNT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic start_i,
    input wire seq_pkg::readout_mode_t mode_i,
    input wire seq_pkg::seq_cfg_t cfg_i,
    input wire logic tdi_step_i,
    // status
    output logic busy_o,
    output logic frame_done_o,
    output logic pixel_strobe_o,
    // sensor controls
    output seq_pkg::sensor_clk_t sensor_o
);
    import seq_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VERT_HI,
        ST_VERT_LO,
        ST_TDI_WAIT,
        ST_HORIZ_HI,
        ST_HORIZ_LO,
        ST_DONE
    } state_t;

    // ============================================================
    // reset release
    // ============================================================
    logic rst_sync1_r;
    logic rst_sync2_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    wire logic rst_n = rst_sync2_r;

    // ============================================================
    // helpers
    // ============================================================
    // a zero count is treated as one so the sequence always advances
    function automatic logic [COUNT_W-1:0] at_least_one(
        input logic [COUNT_W-1:0] v);
        at_least_one = (v == '0) ? {{(COUNT_W-1){1'b0}}, 1'b1} : v;
    endfunction

    // ============================================================
    // state and counters
    // ============================================================
    state_t state_r;
    state_t state_nxt;
    readout_mode_t mode_r;
    seq_cfg_t cfg_r;
    logic [COUNT_W-1:0] tick_r;
    logic [COUNT_W-1:0] tick_nxt;
    logic [COUNT_W-1:0] row_r;
    logic [COUNT_W-1:0] row_nxt;
    logic [COUNT_W-1:0] bin_row_r;
    logic [COUNT_W-1:0] bin_row_nxt;
    logic [COUNT_W-1:0] pix_r;
    logic [COUNT_W-1:0] pix_nxt;
    logic [COUNT_W-1:0] bin_pix_r;
    logic [COUNT_W-1:0] bin_pix_nxt;
    logic [COUNT_W-1:0] rst_cnt_r;
    logic [COUNT_W-1:0] rst_cnt_nxt;
    sensor_clk_t sensor_nxt;

    // decoded settings
    wire logic [COUNT_W-1:0] vhalf = at_least_one(cfg_r.vert_half_cyc);
    wire logic [COUNT_W-1:0] hhalf = at_least_one(cfg_r.horiz_half_cyc);
    // never shorter than the sense node's minimum reset time
    wire logic [COUNT_W-1:0] rpw_min = COUNT_W'(`SEQ_RESET_PULSE_CYC);
    wire logic [COUNT_W-1:0] rpw = (cfg_r.reset_pulse_cyc < rpw_min) ?
        rpw_min : cfg_r.reset_pulse_cyc;
    wire logic [COUNT_W-1:0] nrows = at_least_one(cfg_r.rows_per_frame);
    wire logic [COUNT_W-1:0] npix = at_least_one(cfg_r.pixels_per_line);
    // line binning groups rows; area scan and tdi shift one row per line
    wire logic [COUNT_W-1:0] rows_group =
        (mode_r == MODE_LINE_BIN || mode_r == MODE_PIXEL_BIN) ?
        at_least_one(cfg_r.rows_binned) : {{(COUNT_W-1){1'b0}}, 1'b1};
    // pixel binning merges pixels in the summing well
    wire logic [COUNT_W-1:0] pix_group = (mode_r == MODE_PIXEL_BIN) ?
        at_least_one(cfg_r.pixels_binned) : {{(COUNT_W-1){1'b0}}, 1'b1};
    wire logic tick_end = (tick_r == '0);
    wire logic last_row = (row_r + 1'b1 >= nrows);
    wire logic last_pix = (pix_r + 1'b1 >= npix);
    wire logic group_row_end = (bin_row_r + 1'b1 >= rows_group);
    wire logic group_pix_end = (bin_pix_r + 1'b1 >= pix_group);
    wire logic vert_active = (state_r == ST_VERT_HI);
    wire logic horiz_active = (state_r == ST_HORIZ_HI);
    // summing gate follows phase two, but is held high (charge kept in
    // the well) until the last pixel of a binning group so it falls once
    wire logic sg_hold = horiz_active ||
        (state_r == ST_HORIZ_LO && !group_pix_end);

    // ============================================================
    // next-state logic
    // ============================================================
    always_comb begin
        state_nxt = state_r;
        tick_nxt = tick_end ? '0 : tick_r - 1'b1;
        row_nxt = row_r;
        bin_row_nxt = bin_row_r;
        pix_nxt = pix_r;
        bin_pix_nxt = bin_pix_r;
        rst_cnt_nxt = (rst_cnt_r == '0) ? '0 : rst_cnt_r - 1'b1;
        unique case (state_r)
            ST_IDLE: begin
                if (start_i) begin
                    row_nxt = '0;
                    bin_row_nxt = '0;
                    // tdi waits for motion pacing before each shift
                    state_nxt = (mode_i == MODE_TDI) ? ST_TDI_WAIT
                                                     : ST_VERT_HI;
                    tick_nxt = at_least_one(cfg_i.vert_half_cyc) - 1'b1;
                end
            end
            ST_TDI_WAIT: begin
                if (tdi_step_i) begin
                    state_nxt = ST_VERT_HI;
                    tick_nxt = vhalf - 1'b1;
                end
            end
            ST_VERT_HI: begin
                if (tick_end) begin
                    state_nxt = ST_VERT_LO;
                    tick_nxt = vhalf - 1'b1;
                end
            end
            ST_VERT_LO: begin
                if (tick_end) begin
                    row_nxt = row_r + 1'b1;
                    // sum rows into the horizontal register first
                    if (group_row_end || last_row) begin
                        bin_row_nxt = '0;
                        pix_nxt = '0;
                        bin_pix_nxt = '0;
                        state_nxt = ST_HORIZ_HI;
                        tick_nxt = hhalf - 1'b1;
                    end else begin
                        bin_row_nxt = bin_row_r + 1'b1;
                        state_nxt = ST_VERT_HI;
                        tick_nxt = vhalf - 1'b1;
                    end
                end
            end
            ST_HORIZ_HI: begin
                if (tick_end) begin
                    state_nxt = ST_HORIZ_LO;
                    tick_nxt = hhalf - 1'b1;
                    // reset the sense node ahead of the next charge
                    if (group_pix_end) begin
                        rst_cnt_nxt = rpw;
                    end
                end
            end
            ST_HORIZ_LO: begin
                if (tick_end) begin
                    pix_nxt = pix_r + 1'b1;
                    bin_pix_nxt = group_pix_end ? '0 : bin_pix_r + 1'b1;
                    if (!last_pix) begin
                        state_nxt = ST_HORIZ_HI;
                        tick_nxt = hhalf - 1'b1;
                    end else if (row_r >= nrows) begin
                        state_nxt = ST_DONE; // frame ends
                    end else if (mode_r == MODE_TDI) begin
                        state_nxt = ST_TDI_WAIT;
                    end else begin
                        // vertical starts only after the last pixel
                        state_nxt = ST_VERT_HI;
                        tick_nxt = vhalf - 1'b1;
                    end
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // sensor outputs, all registered
    // ============================================================
    always_comb begin
        sensor_nxt.vert_phase_one = !vert_active; // complement pair
        sensor_nxt.vert_phase_two = vert_active;
        // separate pin, same waveform as phase two; also the half-A
        // phase two on split sensors, so tying is safe
        sensor_nxt.transfer_gate_pulse = vert_active;
        sensor_nxt.horiz_phase_one = !horiz_active;
        sensor_nxt.horiz_phase_two = horiz_active;
        // equals phase two unless pixel binning
        sensor_nxt.summing_gate_pulse = sg_hold;
        sensor_nxt.output_reset_pulse = (rst_cnt_nxt != '0);
    end

    // ============================================================
    // registers
    // ============================================================
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            mode_r <= MODE_AREA;
            cfg_r <= '0;
            tick_r <= '0;
            row_r <= '0;
            bin_row_r <= '0;
            pix_r <= '0;
            bin_pix_r <= '0;
            rst_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            tick_r <= tick_nxt;
            row_r <= row_nxt;
            bin_row_r <= bin_row_nxt;
            pix_r <= pix_nxt;
            bin_pix_r <= bin_pix_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            // settings are latched at start and hold for the frame
            if (state_r == ST_IDLE && start_i) begin
                mode_r <= mode_i;
                cfg_r <= cfg_i;
            end
        end
    end

    // seven controls and status, from flip-flops
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sensor_o <= `SEQ_SENSOR_RESET;
            busy_o <= 1'b0;
            frame_done_o <= 1'b0;
            pixel_strobe_o <= 1'b0;
        end else begin
            sensor_o <= sensor_nxt;
            busy_o <= (state_nxt != ST_IDLE);
            frame_done_o <= (state_nxt == ST_DONE);
            // marks the summing gate fall that dumps a pixel
            pixel_strobe_o <= sensor_o.summing_gate_pulse &&
                !sensor_nxt.summing_gate_pulse;
        end
    end
endmodule

// ---- hw/seq_map.svh ----
/*
 * timing constants for the area sensor clock sequencer.
 * assumes a 125 MHz system clock (8 ns period).
 */
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define SEQ_CLK_PERIOD_NS 8
// reset gate pulse width, about 10 ns to 100 ns; longer is harmless
`define SEQ_RESET_PULSE_MIN_NS 10
`define SEQ_RESET_PULSE_MAX_NS 100
// least time rounds up to whole cycles
`define SEQ_RESET_PULSE_CYC \
    ((`SEQ_RESET_PULSE_MIN_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS)
// default half-period counts for phase clocks, in cycles
`define SEQ_VERT_HALF_CYC 500
`define SEQ_HORIZ_HALF_CYC 125
`define SEQ_COUNT_W 16
// sensor pins in reset: phase ones high, everything else low
`define SEQ_SENSOR_RESET 7'h48
`endif

// ---- hw/seq_pkg.sv ----
/*
 * types for the area sensor clock sequencer.
 * assumes seq_map.svh supplies the counter width.
 */
`include "seq_map.svh"
package seq_pkg;
    // readout mode, chosen purely by sequence ordering and counts
    typedef enum logic [1:0] {
        MODE_LINE_BIN,
        MODE_AREA,
        MODE_PIXEL_BIN,
        MODE_TDI
    } readout_mode_t;

    // programmed frame geometry and pacing
    typedef struct packed {
        logic [`SEQ_COUNT_W-1:0] rows_per_frame;
        logic [`SEQ_COUNT_W-1:0] rows_binned;
        logic [`SEQ_COUNT_W-1:0] pixels_per_line;
        logic [`SEQ_COUNT_W-1:0] pixels_binned;
        logic [`SEQ_COUNT_W-1:0] vert_half_cyc;
        logic [`SEQ_COUNT_W-1:0] horiz_half_cyc;
        logic [`SEQ_COUNT_W-1:0] reset_pulse_cyc;
    } seq_cfg_t;

    // the seven sensor control lines
    typedef struct packed {
        logic vert_phase_one;
        logic vert_phase_two;
        logic transfer_gate_pulse;
        logic horiz_phase_one;
        logic horiz_phase_two;
        logic summing_gate_pulse;
        logic output_reset_pulse;
    } sensor_clk_t;
endpackage

// ---- tb/sensor_model.sv ----
/*
 * behavioural sensor seen from its clock pins: counts rows, charges
 * dumped onto the sense node and reset gate pulses.
 * assumes the pins are sampled on the sequencer clock.
 */
`timescale 1ns/10ps
module sensor_model (
    input wire logic clk_i,
    input wire seq_pkg::sensor_clk_t sensor_i,
    output logic [15:0] rows_o,
    output logic [15:0] charges_o,
    output logic [15:0] resets_o
);
    import seq_pkg::*;
    sensor_clk_t last_r = 7'h48;
    logic [15:0] rows_r = 16'h0000;
    logic [15:0] charges_r = 16'h0000;
    logic [15:0] resets_r = 16'h0000;
    // counters are single-driven; ports only mirror them
    assign rows_o = rows_r;
    assign charges_o = charges_r;
    assign resets_o = resets_r;
    // edges only count; a stuck pin shows up as a missing count
    always @(posedge clk_i) begin
        // gate tied or driven alike, row moves as both climb
        if (sensor_i.vert_phase_two && sensor_i.transfer_gate_pulse &&
            !last_r.vert_phase_two) begin
            rows_r <= rows_r + 16'h0001;
        end
        // charge lands on the sense node at summing gate fall
        if (!sensor_i.summing_gate_pulse && last_r.summing_gate_pulse) begin
            charges_r <= charges_r + 16'h0001;
        end
        if (sensor_i.output_reset_pulse && !last_r.output_reset_pulse) begin
            resets_r <= resets_r + 16'h0001;
        end
        last_r <= sensor_i;
    end
endmodule

// ---- tb/seq_monitor.sv ----
/*
 * port checker for the area sensor clock sequencer.
 * assumes the bench holds mode_i steady through a frame and programs
 * both half periods and the reset pulse width to two cycles.
 */
`timescale 1ns/10ps
module seq_monitor #(
    parameter int COUNT_W = 16
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire seq_pkg::readout_mode_t mode_i,
    input wire seq_pkg::seq_cfg_t cfg_i,
    input wire logic tdi_step_i,
    input wire logic busy_o,
    input wire logic frame_done_o,
    input wire logic pixel_strobe_o,
    input wire seq_pkg::sensor_clk_t sensor_o
);
    import seq_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==================================================
    // phase relations, checked in every cycle except the summing gate one (busy outside pixel binning) and vertical idle (horizontal phase two high)
    tg_match_a: assert property (
        sensor_o.transfer_gate_pulse == sensor_o.vert_phase_two)
        else $error("transfer gate departs from vertical phase two");
    vert_cross_a: assert property (
        sensor_o.vert_phase_one != sensor_o.vert_phase_two)
        else $error("vertical phases not complementary");
    horiz_cross_a: assert property (
        sensor_o.horiz_phase_one != sensor_o.horiz_phase_two)
        else $error("horizontal phases not complementary");
    sum_follow_a: assert property (
        busy_o && mode_i != MODE_PIXEL_BIN
        |-> sensor_o.summing_gate_pulse == sensor_o.horiz_phase_two)
        else $error("summing gate departs from horizontal phase two");
    vert_idle_a: assert property (
        sensor_o.horiz_phase_two |-> !sensor_o.vert_phase_two)
        else $error("vertical clocking during horizontal readout");
    // ==================================================
    // pixel output timing and vertical half period
    charge_strobe_a: assert property (
        pixel_strobe_o == $fell(sensor_o.summing_gate_pulse))
        else $error("pixel strobe not aligned to summing gate fall");
    reset_follow_a: assert property (
        pixel_strobe_o |-> ##[0:2] sensor_o.output_reset_pulse)
        else $error("no reset pulse after pixel charge");
    reset_width_a: assert property (
        $rose(sensor_o.output_reset_pulse)
        |-> sensor_o.output_reset_pulse [*2])
        else $error("reset pulse shorter than programmed");
    vert_half_a: assert property (
        $rose(sensor_o.vert_phase_two)
        |-> sensor_o.vert_phase_two [*2] ##1 !sensor_o.vert_phase_two)
        else $error("vertical half period wrong");
    // ==================================================
    // frame control
    busy_take_a: assert property (
        start_i && !busy_o && !frame_done_o |=> busy_o)
        else $error("start not taken while idle");
    done_end_a: assert property (
        frame_done_o |-> ##[0:1] !busy_o)
        else $error("busy stays up after frame end");
    line_c: cover property (frame_done_o && mode_i == MODE_LINE_BIN);
    pix_c: cover property (frame_done_o && mode_i == MODE_PIXEL_BIN);
    tdi_c: cover property (frame_done_o && mode_i == MODE_TDI);
endmodule

// ---- tb/tb_top.sv ----
/*
 * self-checking bench for the area sensor clock sequencer.
 * assumes half periods and reset pulse of two cycles keep frames short.
 */
`timescale 1ns/10ps
module tb_top;
    import seq_pkg::*;
    localparam int COUNT_W = 16;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    readout_mode_t mode_i = MODE_AREA;
    seq_cfg_t cfg_i = '0;
    logic tdi_step_i = 1'b0;
    logic busy_o;
    logic frame_done_o;
    logic pixel_strobe_o;
    sensor_clk_t sensor_o;
    logic [15:0] rows, charges, resets, r0, c0, q0;
    int fails = 0;
    int n_tests = 0;
    int dones = 0;
    int d0 = 0;
    int strobes = 0;
    int s0 = 0;
    always #4 clk_i = ~clk_i;
    // frame ends counted to catch a refused start that slipped through
    always @(posedge clk_i) begin
        if (frame_done_o === 1'b1) begin
            dones <= dones + 1;
        end
        // each pixel strobe must match one charge seen at the sensor
        if (pixel_strobe_o === 1'b1) begin
            strobes <= strobes + 1;
        end
    end
    area_sensor_clock_sequencer #(.COUNT_W(COUNT_W)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
        .mode_i(mode_i), .cfg_i(cfg_i), .tdi_step_i(tdi_step_i),
        .busy_o(busy_o), .frame_done_o(frame_done_o),
        .pixel_strobe_o(pixel_strobe_o), .sensor_o(sensor_o));
    sensor_model model (.clk_i(clk_i), .sensor_i(sensor_o),
        .rows_o(rows), .charges_o(charges), .resets_o(resets));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    // start a frame, then try a start while busy, which must be ignored
    task automatic go(input readout_mode_t m, input logic [15:0] rpf,
            rb, ppl, pb);
        r0 = rows;
        c0 = charges;
        q0 = resets;
        d0 = dones;
        s0 = strobes;
        mode_i = m;
        cfg_i = {rpf, rb, ppl, pb, 16'h0002, 16'h0002, 16'h0002};
        start_i = 1'b1;
        tick(1);
        check(busy_o, 1);
        tick(2);
        check(busy_o, 1);
    endtask
    task automatic finish_frame();
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < 20000) begin
            tick(1);
            k++;
        end
        start_i = 1'b0;
        if (k >= 20000) begin
            fails++;
            print_verdict();
        end
        tick(6);
        check(dones - d0, 1);
        check(resets - q0, charges - c0);
        check(strobes - s0, charges - c0);
    endtask
    task automatic line_bin();
        go(MODE_LINE_BIN, 16'h0004, 16'h0002, 16'h0003, 16'h0001);
        finish_frame();
        check(rows - r0, 4);
        check(charges - c0, 6);
    endtask
    task automatic area_scan();
        go(MODE_AREA, 16'h0003, 16'h0002, 16'h0002, 16'h0001);
        finish_frame();
        check(rows - r0, 3);
        check(charges - c0, 6);
    endtask
    task automatic pixel_bin();
        go(MODE_PIXEL_BIN, 16'h0002, 16'h0001, 16'h0004, 16'h0002);
        finish_frame();
        check(charges - c0, 4);
        go(MODE_PIXEL_BIN, 16'h0004, 16'h0002, 16'h0004, 16'h0002);
        finish_frame();
        check(rows - r0, 4);
        check(charges - c0, 4);
    endtask
    task automatic tdi_paced();
        go(MODE_TDI, 16'h0002, 16'h0001, 16'h0002, 16'h0001);
        tick(40);
        check(rows - r0, 0);
        check(busy_o, 1);
        tdi_step_i = 1'b1;
        finish_frame();
        tdi_step_i = 1'b0;
        check(rows - r0, 2);
        check(charges - c0, 4);
    endtask
    initial begin
        tick(4);
        check(sensor_o, 7'h48);
        check(busy_o, 0);
        reset_n_i = 1'b1;
        tick(3);
        line_bin();
        area_scan();
        pixel_bin();
        tdi_paced();
        print_verdict();
    end
endmodule
bind area_sensor_clock_sequencer seq_monitor #(.COUNT_W(COUNT_W)) mon (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
    .mode_i(mode_i), .cfg_i(cfg_i), .tdi_step_i(tdi_step_i),
    .busy_o(busy_o), .frame_done_o(frame_done_o),
    .pixel_strobe_o(pixel_strobe_o), .sensor_o(sensor_o));
